/* File: hdl/slpd_defines.vh */
`ifndef SLPD_DEFINES_VH
`define SLPD_DEFINES_VH
// Register map
`define SLPD_ADDR_W 16
`define SLPD_CTRL_ADDR 16'h404C
`define SLPD_CTRL_RESET 16'hC026
`define SLPD_CTRL_MASK 16'hC33F
// Field positions
`define SLPD_SRC_HI 15
`define SLPD_SRC_LO 14
`define SLPD_MODE_HI 9
`define SLPD_MODE_LO 8
`define SLPD_LEN_HI 5
`define SLPD_LEN_LO 4
`define SLPD_ONT_HI 3
`define SLPD_ONT_LO 2
`define SLPD_RAT_HI 1
`define SLPD_RAT_LO 0
// Source selector codes
`define SLPD_SRC_OFF 2'h0
`define SLPD_SRC_PWR 2'h1
`define SLPD_SRC_CHG 2'h2
`define SLPD_SRC_MAN 2'h3
// Pattern mode codes
`define SLPD_MODE_OFF 2'h0
`define SLPD_MODE_ON 2'h1
`define SLPD_MODE_CONT 2'h2
`define SLPD_MODE_BURST 2'h3
// Timing: base on-time step is 62.5 ms = 62500 us; clock 50 MHz
`define SLPD_CLK_MHZ 50
`define SLPD_TICK_US 62500
`define SLPD_TICK_CYC (`SLPD_TICK_US * `SLPD_CLK_MHZ)
// OTP completion flash length in ticks
`define SLPD_OTP_TICKS 5'h10
`endif

/* File: hdl/slpd_status_led_pulse_driver.v */
// Chosen here: the plain strobed port.
`timescale 1ns/100ps
`include "slpd_defines.vh"
module slpd_status_led_pulse_driver #(
   parameter TICK_CYC = `SLPD_TICK_CYC
) (
   // Clock, reset, enable
   input wire clk,
   input wire rstn,
   input wire clk_en,
   // Register port
   input wire [15:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [15:0] reg_rdata,
   // Status sources from the rest of the device (asynchronous)
   input wire power_state_led,
   input wire charger_status_led,
   input wire otp_prog_done,
   // Indicator
   output reg led_out
);

////////////////////////////////////////////////////////////////////////////////
// Helpers
function [3:0] on_ticks;
   input [1:0] code;
   begin
      case (code)
         2'h0: on_ticks = 4'hF;
         2'h1: on_ticks = 4'h3;
         2'h2: on_ticks = 4'h1;
         default: on_ticks = 4'h0;
      endcase
   end
endfunction

function [2:0] ratio_mult;
   input [1:0] code;
   begin
      case (code)
         2'h0: ratio_mult = 3'h1;
         2'h1: ratio_mult = 3'h2;
         2'h2: ratio_mult = 3'h3;
         default: ratio_mult = 3'h7;
      endcase
   end
endfunction

function [2:0] burst_pulses;
   input [1:0] code;
   begin
      case (code)
         2'h0: burst_pulses = 3'h1;
         2'h1: burst_pulses = 3'h2;
         2'h2: burst_pulses = 3'h4;
         default: burst_pulses = 3'h7;
      endcase
   end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Input synchronisers
reg [2:0] sync1;
reg [2:0] sync2;
reg otp_prev;

always @(posedge clk or negedge rstn) begin
   if (!rstn) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      otp_prev <= 1'b0;
   end else if (clk_en) begin
      sync1 <= {otp_prog_done, charger_status_led, power_state_led};
      sync2 <= sync1;
      otp_prev <= sync2[2];
   end
end

wire otp_rise = sync2[2] & ~otp_prev;

////////////////////////////////////////////////////////////////////////////////
// Register
reg [15:0] ctrl;
wire wr_hit = reg_wr && (reg_addr == `SLPD_CTRL_ADDR);
wire [1:0] src = ctrl[`SLPD_SRC_HI:`SLPD_SRC_LO];
wire [1:0] mode = ctrl[`SLPD_MODE_HI:`SLPD_MODE_LO];
wire [1:0] len = ctrl[`SLPD_LEN_HI:`SLPD_LEN_LO];
wire [1:0] ont = ctrl[`SLPD_ONT_HI:`SLPD_ONT_LO];
wire [1:0] rat = ctrl[`SLPD_RAT_HI:`SLPD_RAT_LO];

always @(posedge clk or negedge rstn) begin
   if (!rstn) begin
      ctrl <= `SLPD_CTRL_RESET;
      reg_rdata <= 16'h0000;
   end else if (clk_en) begin
      if (wr_hit) begin
         ctrl <= reg_wdata & `SLPD_CTRL_MASK;
      end
      if (reg_rd && (reg_addr == `SLPD_CTRL_ADDR)) begin
         reg_rdata <= ctrl;
      end else begin
         reg_rdata <= 16'h0000;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// Reference tick
reg [31:0] tick_cnt;
wire tick = (tick_cnt == TICK_CYC - 1);

always @(posedge clk or negedge rstn) begin
   if (!rstn) begin
      tick_cnt <= 32'h0;
   end else if (clk_en) begin
      if (wr_hit || tick) begin
         tick_cnt <= 32'h0;
      end else begin
         tick_cnt <= tick_cnt + 32'h1;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// Pattern generator
localparam ST_ON = 1'b0;
localparam ST_OFF = 1'b1;
reg state;
reg [3:0] sub_cnt;
reg [2:0] rep_cnt;
reg [2:0] pulse_cnt;
reg burst_done;
reg [4:0] otp_cnt;

wire pulsing = (mode == `SLPD_MODE_CONT) || (mode == `SLPD_MODE_BURST);

always @(posedge clk or negedge rstn) begin
   if (!rstn) begin
      state <= ST_ON;
      sub_cnt <= 4'h0;
      rep_cnt <= 3'h0;
      pulse_cnt <= 3'h0;
      burst_done <= 1'b0;
   end else if (clk_en) begin
      if (wr_hit) begin
         state <= ST_ON;
         sub_cnt <= 4'h0;
         rep_cnt <= 3'h0;
         pulse_cnt <= 3'h0;
         burst_done <= 1'b0;
      end else if (tick && pulsing && !burst_done) begin
         case (state)
            ST_ON: begin
               if (sub_cnt == on_ticks(ont)) begin
                  sub_cnt <= 4'h0;
                  state <= ST_OFF;
               end else begin
                  sub_cnt <= sub_cnt + 4'h1;
               end
            end
            default: begin
               if (sub_cnt == on_ticks(ont)) begin
                  sub_cnt <= 4'h0;
                  if (rep_cnt == ratio_mult(rat) - 3'h1) begin
                     rep_cnt <= 3'h0;
                     state <= ST_ON;
                     if (mode == `SLPD_MODE_BURST &&
                         pulse_cnt == burst_pulses(len) - 3'h1) begin
                        burst_done <= 1'b1;
                     end else begin
                        pulse_cnt <= pulse_cnt + 3'h1;
                     end
                  end else begin
                     rep_cnt <= rep_cnt + 3'h1;
                  end
               end else begin
                  sub_cnt <= sub_cnt + 4'h1;
               end
            end
         endcase
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// OTP completion flash overrides the selected function for a fixed time
always @(posedge clk or negedge rstn) begin
   if (!rstn) begin
      otp_cnt <= 5'h0;
   end else if (clk_en) begin
      if (otp_rise) begin
         otp_cnt <= `SLPD_OTP_TICKS;
      end else if (tick && otp_cnt != 5'h0) begin
         otp_cnt <= otp_cnt - 5'h1;
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// Output select
reg next_led;
always @* begin
   case (mode)
      `SLPD_MODE_ON: next_led = 1'b1;
      `SLPD_MODE_CONT: next_led = (state == ST_ON);
      `SLPD_MODE_BURST: next_led = (state == ST_ON) && !burst_done;
      default: next_led = 1'b0;
   endcase
   if (src == `SLPD_SRC_OFF) begin
      next_led = 1'b0;
   end else if (src == `SLPD_SRC_PWR) begin
      next_led = sync2[0];
   end else if (src == `SLPD_SRC_CHG) begin
      next_led = sync2[1];
   end
   if (otp_cnt != 5'h0) begin
      next_led = 1'b1;
   end
end

always @(posedge clk or negedge rstn) begin
   if (!rstn) begin
      led_out <= 1'b0;
   end else if (clk_en) begin
      led_out <= next_led;
   end
end

endmodule

/* File: tb/slpd_chk.sv */
`timescale 1ns/100ps
`include "slpd_defines.vh"
module slpd_chk #(parameter TICK_CYC = 4) (
   // Clock, reset, enable
   input wire clk,
   input wire rstn,
   input wire clk_en,
   // Register port
   input wire [15:0] reg_addr,
   input wire [15:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   input wire [15:0] reg_rdata,
   // Status sources
   input wire power_state_led,
   input wire charger_status_led,
   input wire otp_prog_done,
   // Indicator
   input wire led_out
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   reg [15:0] ctl;
   reg [15:0] run;
   reg seen;
   reg led_q;
   // A strobe while the clock enable is low leaves the register alone
   wire hit = clk_en && reg_wr && reg_addr == `SLPD_CTRL_ADDR;
   wire [4:0] on_t = ctl[3:2] == 2'h0 ? 5'h10 : 5'h8 >> ctl[3:2];
   wire [2:0] k = ctl[1:0] == 2'h3 ? 3'h7 : {1'b0, ctl[1:0]} + 3'h1;
   wire pulsing = ctl[15:14] == 2'h3 && ctl[9] && !otp_prog_done;
   // Off length is only judged after a full pulse, since a write restarts the pattern
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctl <= `SLPD_CTRL_RESET;
         run <= 16'h0;
         seen <= 1'b0;
         led_q <= 1'b0;
      end else begin
         if (hit) ctl <= reg_wdata & `SLPD_CTRL_MASK;
         led_q <= led_out;
         run <= (led_out != led_q) ? 16'h1 : run + 16'h1;
         seen <= hit ? 1'b0 : seen | (led_q & ~led_out);
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   AST_RDATA: assert property (
      reg_rdata == ($past(reg_rd) && $past(reg_addr) == `SLPD_CTRL_ADDR ? $past(ctl) : 16'h0))
      else $error("read data wrong");
   AST_DARK: assert property (
      $past(ctl[15:14] == 2'h0 || ctl[15:8] == 8'hC0) && !otp_prog_done |-> !led_out)
      else $error("indicator lit while dark");
   AST_STEADY: assert property ($past(ctl[15:8] == 8'hC1) |-> led_out)
      else $error("indicator not steady");
   AST_POWER: assert property (
      (ctl[15:14] == 2'h1 && !otp_prog_done) [*4] |-> led_out == $past(power_state_led, 3))
      else $error("power state not shown");
   AST_CHARGER: assert property (
      (ctl[15:14] == 2'h2 && !otp_prog_done) [*4] |-> led_out == $past(charger_status_led, 3))
      else $error("charger status not shown");
   AST_ON_LEN: assert property (
      $fell(led_out) && pulsing |-> run == on_t * TICK_CYC)
      else $error("on time wrong");
   AST_OFF_LEN: assert property (
      $rose(led_out) && pulsing && seen |-> run == on_t * k * TICK_CYC)
      else $error("off time wrong");
   AST_OTP: assert property ($rose(otp_prog_done) |-> ##[3:4] led_out)
      else $error("programming completion not shown");
   cover property ($fell(led_out) && ctl[9:8] == 2'h3);
   cover property (reg_rd && reg_addr != `SLPD_CTRL_ADDR);
   cover property ($rose(otp_prog_done));
endmodule
bind slpd_status_led_pulse_driver slpd_chk #(.TICK_CYC(TICK_CYC)) i_chk (.*);

/* File: tb/slpd_led_model.sv */
`timescale 1ns/100ps
module slpd_led_model (
   input wire clk,
   input wire clr,
   input wire led_out,
   output reg [7:0] pulses
);
   reg led_q;
   // Counts lit pulses as an eye would, one per turn-on
   always @(posedge clk) begin
      led_q <= led_out;
      pulses <= clr ? 8'h0 : pulses + {7'h0, led_out & ~led_q};
   end
endmodule

/* File: tb/status_led_pulse_driver_tb_top.sv */
`timescale 1ns/100ps
`include "slpd_defines.vh"
module status_led_pulse_driver_tb_top;
   localparam T = 4;
   reg clk = 1'b0;
   reg rstn = 1'b0;
   reg wr = 1'b0;
   reg rd = 1'b0;
   reg pwr = 1'b0;
   reg chg = 1'b0;
   reg otp = 1'b0;
   reg clr = 1'b1;
   reg en = 1'b1;
   reg [15:0] addr = 16'h0;
   reg [15:0] wdata = 16'h0;
   wire [15:0] rdata;
   wire led;
   wire [7:0] pulses;
   integer num_errors = 0;
   integer checks_done = 0;
   integer i;
   integer n;
   always #10 clk = ~clk;
   slpd_status_led_pulse_driver #(.TICK_CYC(T)) i_dut (.clk(clk), .rstn(rstn), .clk_en(en),
      .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
      .power_state_led(pwr), .charger_status_led(chg), .otp_prog_done(otp), .led_out(led));
   slpd_led_model i_led (.clk(clk), .clr(clr), .led_out(led), .pulses(pulses));
   ////////////////////////////////////////////////////////////////////////////////
   task check(input [15:0] seen, input [15:0] exp);
      begin
         checks_done = checks_done + 1;
         if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task write(input [15:0] a, input [15:0] d);
      begin
         addr <= a;
         wdata <= d;
         wr <= 1'b1;
         @(posedge clk);
         wr <= 1'b0;
         @(posedge clk);
      end
   endtask
   task read(input [15:0] a, input [15:0] exp);
      begin
         addr <= a;
         rd <= 1'b1;
         @(posedge clk);
         rd <= 1'b0;
         #1 check(rdata, exp);
         @(posedge clk);
      end
   endtask
   // Parks the output dark first so every pattern starts from a clean off phase
   task start(input [15:0] d);
      begin
         clr <= 1'b1;
         write(`SLPD_CTRL_ADDR, 16'hC000);
         write(`SLPD_CTRL_ADDR, d);
         clr <= 1'b0;
      end
   endtask
   task report_and_stop;
      begin
         $display("Checks %0d, errors %0d", checks_done, num_errors);
         if (num_errors == 0 && checks_done > 0)
            $display("Test passed");
         else
            $display("Test failed");
         $finish;
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #200000;
      num_errors = num_errors + 1;
      report_and_stop;
   end
   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      read(`SLPD_CTRL_ADDR, `SLPD_CTRL_RESET);
      write(`SLPD_CTRL_ADDR, 16'hFFFF);
      read(`SLPD_CTRL_ADDR, `SLPD_CTRL_MASK);
      read(16'h404D, 16'h0000);
      for (i = 0; i < 16; i = i + 1) begin
         start(16'hC200 | i[3:0]);
         n = (i[3:2] == 0 ? 16 : 8 >> i[3:2]) * T;
         repeat (n * (i[1:0] == 3 ? 8 : i[1:0] + 2) + 4) @(posedge clk);
         check(pulses, 16'h2);
      end
      for (i = 0; i < 4; i = i + 1) begin
         start(16'hC30C | (i[1:0] << 4));
         repeat (80) @(posedge clk);
         check(pulses, i == 3 ? 16'h7 : 16'h1 << i);
      end
      for (i = 0; i < 4; i = i + 1) begin
         write(`SLPD_CTRL_ADDR, {i[1:0], 14'h0100});
         pwr <= i[0];
         chg <= i[1];
         repeat (6) @(posedge clk);
         check(led, i != 0);
      end
      write(`SLPD_CTRL_ADDR, 16'hC000);
      // A write while the clock enable is low must not land
      en <= 1'b0;
      write(`SLPD_CTRL_ADDR, 16'hC100);
      en <= 1'b1;
      read(`SLPD_CTRL_ADDR, 16'hC000);
      otp <= 1'b1;
      repeat (10) @(posedge clk);
      check(led, 1'b1);
      repeat (70) @(posedge clk);
      check(led, 1'b0);
      report_and_stop;
   end
endmodule
